// >>> inc/cno_pkg.sv
// Notes on behaviour
// - after startup enter pre-operational without command
// - disconnected none, connecting guard, preparing NMT/SDO, prepared emergency
// - pre-operational adds SYNC; PDOs only when operational
// - NMT 130, 129, 128 lead to pre-operational
// - NMT 2 to prepared, 1 to operational
// - guard request answered with current state code
// - optional guard timeout flags network fault
// - internal errors sent as emergency message
// - two SDO channels, 16-bit index plus subindex
// - four receive, four transmit PDOs when operational
// - PDOs follow transmission type 0, 252, 253, 254
// - node ID change reloads NMT, SYNC, emergency, guard IDs
// - PDO identifiers are node ID plus base
// - SDO identifiers are node ID plus base
// - identifier overrides kept until node ID changes
// - node ID 1 to 127, default 63
// - bit-rate codes 0..7 map to rate table
// - default bit rate 500 kbit/s, code 2
// - switch box gives ID nibbles and rate code
// - LED red on error, yellow waiting, green ready
package cno_pkg;

  // network states of the node
  typedef enum logic [2:0] {
    ST_DISC  = 3'b000,
    ST_CONN  = 3'b001,
    ST_PREPG = 3'b010,
    ST_PREPD = 3'b011,
    ST_PREOP = 3'b100,
    ST_OPER  = 3'b101
  } cno_state_t;

  // state codes returned in the guard reply
  localparam logic [6:0] CODE_DISC  = 7'h01;
  localparam logic [6:0] CODE_CONN  = 7'h02;
  localparam logic [6:0] CODE_PREPG = 7'h03;
  localparam logic [6:0] CODE_PREPD = 7'h04;
  localparam logic [6:0] CODE_OPER  = 7'h05;
  localparam logic [6:0] CODE_PREOP = 7'h7f;

  // network management command numbers
  localparam logic [7:0] NMT_START     = 8'h01;
  localparam logic [7:0] NMT_STOP      = 8'h02;
  localparam logic [7:0] NMT_INIT_NODE = 8'h80;
  localparam logic [7:0] NMT_RST_NODE  = 8'h81;
  localparam logic [7:0] NMT_RST_COMM  = 8'h82;

  // PDO transmission types
  localparam logic [7:0] TT_SYNC_ACYC  = 8'h00;
  localparam logic [7:0] TT_SYNC_RTR   = 8'hfc;
  localparam logic [7:0] TT_ASYNC_RTR  = 8'hfd;
  localparam logic [7:0] TT_ASYNC      = 8'hfe;

  // identifier table: index, base, and whether the node ID is added
  localparam int         COB_NUM = 16;
  localparam int         COB_W   = 11;
  typedef enum logic [3:0] {
    CI_NMT   = 4'h0, CI_SYNC  = 4'h1, CI_EMCY  = 4'h2, CI_GUARD = 4'h3,
    CI_TPDO1 = 4'h4, CI_RPDO1 = 4'h5, CI_TPDO2 = 4'h6, CI_RPDO2 = 4'h7,
    CI_TPDO3 = 4'h8, CI_RPDO3 = 4'h9, CI_TPDO4 = 4'ha, CI_RPDO4 = 4'hb,
    CI_TSDO1 = 4'hc, CI_RSDO1 = 4'hd, CI_TSDO2 = 4'he, CI_RSDO2 = 4'hf
  } cno_cob_idx_t;
  localparam logic [COB_W-1:0] COB_BASE [COB_NUM] = '{
    11'h000, 11'h080, 11'h080, 11'h700,
    11'h180, 11'h200, 11'h280, 11'h300,
    11'h380, 11'h400, 11'h480, 11'h500,
    11'h580, 11'h600, 11'h680, 11'h780};
  localparam logic [COB_NUM-1:0] COB_ADD_ID = 16'hfffc;

  // node ID and bit-rate defaults and limits
  localparam logic [6:0] NODE_ID_DEFAULT = 7'h3f;
  localparam logic [6:0] NODE_ID_MIN     = 7'h01;
  localparam logic [3:0] RATE_MAX_CODE   = 4'h7;
  localparam logic [2:0] RATE_DEFAULT    = 3'h2;
  localparam logic [9:0] RATE_KBPS [8] = '{
    10'd1000, 10'd800, 10'd500, 10'd250, 10'd125, 10'd50, 10'd20, 10'd10};

  // guard watchdog timing
  localparam int CLK_MHZ          = 100;
  localparam int GUARD_TIMEOUT_MS = 100;
  localparam int GUARD_TIMEOUT_CYC = GUARD_TIMEOUT_MS * 1000 * CLK_MHZ;

endpackage : cno_pkg

// >>> hw/cno_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin levels
module cno_sync2 #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= pin_in;
      sync_out <= meta_ff;
    end
  end
endmodule : cno_sync2
`default_nettype wire

// >>> hw/cno_pdo_trig.sv
`timescale 1ns/1ps
`default_nettype none
// transmit trigger for one PDO, by transmission type
module cno_pdo_trig
  import cno_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [7:0] tx_type,
  input  wire logic       sync_pulse,
  input  wire logic       rtr_pulse,
  input  wire logic       event_pulse,
  output var  logic       fire_ff
);
  logic pend_ff;
  wire  t_sacyc = (tx_type == TT_SYNC_ACYC);
  wire  t_srtr  = (tx_type == TT_SYNC_RTR);
  wire  t_artr  = (tx_type == TT_ASYNC_RTR);
  wire  t_async = (tx_type == TT_ASYNC);
  // synchronous types collect a cause and send at the next SYNC
  wire  cause   = (t_sacyc & event_pulse) | (t_srtr & rtr_pulse);
  wire  sync_go = (t_sacyc | t_srtr) & sync_pulse & pend_ff;
  wire  async_go = (t_artr & rtr_pulse) | (t_async & event_pulse);
  wire  nxt_fire = enable & (sync_go | async_go);

  // pending cause: a new cause wins over the clear at SYNC
  always_ff @(posedge clk_sys)
  begin
    if (reset | ~enable)
    begin
      pend_ff <= 1'b0;
      fire_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= cause | (pend_ff & ~sync_go);
      fire_ff <= nxt_fire;
    end
  end
endmodule : cno_pdo_trig
`default_nettype wire

// >>> hw/cno_node_top.sv
`timescale 1ns/1ps
`default_nettype none
// communication-layer control of a CANopen slave node
module cno_node_top
  import cno_pkg::*;
#(
  parameter int GUARD_CYC = GUARD_TIMEOUT_CYC
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     startup_done,
  input  wire logic                     box_attached,
  input  wire logic [3:0]               node_id_high_nibble_switch,
  input  wire logic [3:0]               node_id_low_nibble_switch,
  input  wire logic [3:0]               bit_rate_select_switch,
  input  wire logic                     cfg_id_wr,
  input  wire logic [6:0]               cfg_id,
  input  wire logic                     cfg_rate_wr,
  input  wire logic [3:0]               cfg_rate,
  input  wire logic                     comm_error,
  input  wire logic                     nmt_valid,
  input  wire logic [7:0]               nmt_cmd,
  input  wire logic                     guard_req,
  input  wire logic                     guard_mon_en,
  input  wire logic                     sync_rx,
  input  wire logic                     err_event,
  input  wire logic [15:0]              err_code,
  input  wire logic [1:0]               sdo_req,
  input  wire logic [31:0]              sdo_index,
  input  wire logic [15:0]              sdo_subindex,
  input  wire logic                     cob_wr,
  input  wire logic [3:0]               cob_wr_sel,
  input  wire logic [COB_W-1:0]         cob_wr_data,
  input  wire logic [31:0]              tpdo_type,
  input  wire logic [3:0]               tpdo_rtr,
  input  wire logic [3:0]               tpdo_event,
  input  wire logic [3:0]               rpdo_rx,
  output var  logic [6:0]               state_code_ff,
  output var  logic                     guard_reply_ff,
  output var  logic [6:0]               guard_code_ff,
  output var  logic                     guard_fault_ff,
  output var  logic                     sync_taken_ff,
  output var  logic                     emcy_tx_ff,
  output var  logic [15:0]              emcy_code_ff,
  output var  logic [1:0]               sdo_grant_ff,
  output var  logic [31:0]              sdo_index_ff,
  output var  logic [15:0]              sdo_subindex_ff,
  output var  logic [3:0]               tpdo_fire_ff,
  output var  logic [3:0]               rpdo_accept_ff,
  output var  logic [6:0]               node_id_ff,
  output var  logic [2:0]               rate_code_ff,
  output var  logic [9:0]               rate_kbps_ff,
  output var  logic [COB_NUM*COB_W-1:0] cob_table_ff,
  output var  logic                     led_red_ff,
  output var  logic                     led_yellow_ff,
  output var  logic                     led_green_ff
);

  // parameter check
  if (GUARD_CYC < 2)
  begin : g_bad_guard
    $error("GUARD_CYC must be at least 2");
  end

  cno_state_t state_ff;
  cno_state_t nxt_state;
  logic [6:0] prev_id_ff;
  logic       id_err_ff;
  logic       rate_err_ff;
  logic       init_done_ff;
  logic [31:0] guard_cnt_ff;
  logic [3:0] sw_hi;
  logic [3:0] sw_lo;
  logic [3:0] sw_rate;
  logic       box_sync;
  logic [3:0] tpdo_fire_w;

  // switch pins pass two flip-flops before use
  cno_sync2 #(.W(13)) u_sw_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_in   ({node_id_high_nibble_switch, node_id_low_nibble_switch, bit_rate_select_switch, box_attached}),
    .sync_out ({sw_hi, sw_lo, sw_rate, box_sync})
  );

  // service availability by state
  wire st_guard = (state_ff != ST_DISC);
  wire st_nmt   = (state_ff == ST_PREPG) | (state_ff == ST_PREPD) |
                  (state_ff == ST_PREOP) | (state_ff == ST_OPER);
  wire st_emcy  = (state_ff == ST_PREPD) | (state_ff == ST_PREOP) |
                  (state_ff == ST_OPER);
  wire st_sync  = (state_ff == ST_PREOP) | (state_ff == ST_OPER);
  wire st_pdo   = (state_ff == ST_OPER);

  // command decode
  wire nmt_go      = nmt_valid & st_nmt;
  wire nmt_to_pre  = nmt_go & ((nmt_cmd == NMT_RST_COMM) | (nmt_cmd == NMT_RST_NODE) |
                               (nmt_cmd == NMT_INIT_NODE));
  wire nmt_to_stop = nmt_go & (nmt_cmd == NMT_STOP);
  wire nmt_to_op   = nmt_go & (nmt_cmd == NMT_START);
  wire startup_end = (state_ff == ST_PREPG) & startup_done & ~init_done_ff;

  // state walk: startup, then NMT commands only; unknown numbers change nothing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_DISC:  nxt_state = ST_CONN;
      ST_CONN:  nxt_state = ST_PREPG;
      ST_PREPG:
      begin
        if (startup_end)
          nxt_state = ST_PREOP;
      end
      ST_PREPD, ST_PREOP, ST_OPER:
      begin
        if (nmt_to_pre)
          nxt_state = ST_PREOP;
        else if (nmt_to_stop)
          nxt_state = ST_PREPD;
        else if (nmt_to_op)
          nxt_state = ST_OPER;
        else
          nxt_state = state_ff;
      end
      default:  nxt_state = ST_DISC;
    endcase
  end

  // state code of the next state
  wire [6:0] nxt_code = (nxt_state == ST_DISC)  ? CODE_DISC  :
                        (nxt_state == ST_CONN)  ? CODE_CONN  :
                        (nxt_state == ST_PREPG) ? CODE_PREPG :
                        (nxt_state == ST_PREPD) ? CODE_PREPD :
                        (nxt_state == ST_OPER)  ? CODE_OPER  : CODE_PREOP;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_ff      <= ST_DISC;
      state_code_ff <= CODE_DISC;
    end
    else
    begin
      state_ff      <= nxt_state;
      state_code_ff <= nxt_code;
    end
  end

  // node ID sources: switch box at startup, else configuration write
  wire [6:0] sw_id     = {sw_hi[2:0], sw_lo};
  wire       sw_id_ok  = (sw_hi <= 4'h7) & (sw_id >= NODE_ID_MIN);
  wire       cfg_id_ok = (cfg_id >= NODE_ID_MIN);
  wire       take_sw   = startup_end & box_sync;
  wire       take_cfg  = cfg_id_wr & ~take_sw;
  wire       sw_rate_ok  = (sw_rate <= RATE_MAX_CODE);
  wire       cfg_rate_ok = (cfg_rate <= RATE_MAX_CODE);
  wire       take_cfg_rate = cfg_rate_wr & ~take_sw;

  // node ID register with range check; a rejected value keeps the old ID
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      node_id_ff <= NODE_ID_DEFAULT;
      id_err_ff  <= 1'b0;
    end
    else if (take_sw)
    begin
      if (sw_id_ok)
        node_id_ff <= sw_id;
      id_err_ff  <= ~sw_id_ok;
    end
    else if (take_cfg)
    begin
      if (cfg_id_ok)
        node_id_ff <= cfg_id;
      id_err_ff  <= ~cfg_id_ok;
    end
  end

  // bit-rate selection; default code 2 for 500 kbit/s
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rate_code_ff <= RATE_DEFAULT;
      rate_kbps_ff <= RATE_KBPS[RATE_DEFAULT];
      rate_err_ff  <= 1'b0;
    end
    else if (take_sw)
    begin
      if (sw_rate_ok)
      begin
        rate_code_ff <= sw_rate[2:0];
        rate_kbps_ff <= RATE_KBPS[sw_rate[2:0]];
      end
      rate_err_ff  <= ~sw_rate_ok;
    end
    else if (take_cfg_rate)
    begin
      if (cfg_rate_ok)
      begin
        rate_code_ff <= cfg_rate[2:0];
        rate_kbps_ff <= RATE_KBPS[cfg_rate[2:0]];
      end
      rate_err_ff  <= ~cfg_rate_ok;
    end
  end

  // identifier table: reload on ID change, else accept overrides
  wire id_changed = (node_id_ff != prev_id_ff);
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prev_id_ff   <= '0;
      cob_table_ff <= '0;
    end
    else
    begin
      prev_id_ff <= node_id_ff;
      for (int i = 0; i < COB_NUM; i++)
      begin
        if (id_changed)
          cob_table_ff[i*COB_W +: COB_W] <= COB_BASE[i] +
            (COB_ADD_ID[i] ? {4'h0, node_id_ff} : 11'h000);
        else if (cob_wr && (cob_wr_sel == 4'(i)))
          cob_table_ff[i*COB_W +: COB_W] <= cob_wr_data;
      end
    end
  end

  // guard reply and optional guard watchdog
  wire guard_ok  = guard_req & st_guard;
  wire guard_hit = guard_mon_en & st_guard & (guard_cnt_ff >= 32'(GUARD_CYC - 1));
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      guard_reply_ff <= 1'b0;
      guard_code_ff  <= CODE_DISC;
      guard_cnt_ff   <= '0;
      guard_fault_ff <= 1'b0;
    end
    else
    begin
      guard_reply_ff <= guard_ok;
      if (guard_ok)
        guard_code_ff <= state_code_ff;
      if (guard_ok | ~guard_mon_en | ~st_guard)
        guard_cnt_ff <= '0;
      else if (!guard_hit)
        guard_cnt_ff <= guard_cnt_ff + 32'h1;
      // set by the watchdog wins over the clear by a request
      guard_fault_ff <= guard_hit | (guard_fault_ff & ~guard_ok);
    end
  end

  // SYNC, emergency and SDO gating
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_taken_ff   <= 1'b0;
      emcy_tx_ff      <= 1'b0;
      emcy_code_ff    <= '0;
      sdo_grant_ff    <= '0;
      sdo_index_ff    <= '0;
      sdo_subindex_ff <= '0;
    end
    else
    begin
      sync_taken_ff <= sync_rx & st_sync;
      emcy_tx_ff    <= err_event & st_emcy;
      if (err_event & st_emcy)
        emcy_code_ff <= err_code;
      sdo_grant_ff  <= sdo_req & {2{st_nmt}};
      for (int c = 0; c < 2; c++)
      begin
        if (sdo_req[c] & st_nmt)
        begin
          sdo_index_ff[c*16 +: 16]   <= sdo_index[c*16 +: 16];
          sdo_subindex_ff[c*8 +: 8]  <= sdo_subindex[c*8 +: 8];
        end
      end
    end
  end

  // four transmit PDO triggers, live only when operational
  for (genvar p = 0; p < 4; p++)
  begin : g_tpdo
    cno_pdo_trig u_trig (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .enable      (st_pdo),
      .tx_type     (tpdo_type[p*8 +: 8]),
      .sync_pulse  (sync_rx & st_sync),
      .rtr_pulse   (tpdo_rtr[p]),
      .event_pulse (tpdo_event[p]),
      .fire_ff     (tpdo_fire_w[p])
    );
  end

  // PDO outputs
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tpdo_fire_ff   <= '0;
      rpdo_accept_ff <= '0;
    end
    else
    begin
      tpdo_fire_ff   <= tpdo_fire_w & {4{st_pdo}};
      rpdo_accept_ff <= rpdo_rx & {4{st_pdo}};
    end
  end

  // state indicator: red on error, yellow until initialised, then green
  wire any_err = id_err_ff | rate_err_ff | comm_error | guard_fault_ff;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      init_done_ff  <= 1'b0;
      led_red_ff    <= 1'b0;
      led_yellow_ff <= 1'b1;
      led_green_ff  <= 1'b0;
    end
    else
    begin
      if (startup_end)
        init_done_ff <= 1'b1;
      led_red_ff    <= any_err;
      led_yellow_ff <= ~any_err & ~init_done_ff;
      led_green_ff  <= ~any_err & init_done_ff;
    end
  end

endmodule : cno_node_top
`default_nettype wire

// >>> tb/cno_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master: management commands, guard requests, sync
module cno_master_model (
  input  wire logic       clk_sys,
  output var  logic       nmt_valid,
  output var  logic [7:0] nmt_cmd,
  output var  logic       guard_req,
  output var  logic       sync_rx
);
  // idle until asked
  initial
  begin
    {nmt_valid, guard_req, sync_rx} = 3'b000;
    nmt_cmd = 8'h00;
  end

  // one-cycle command; byte scrambled once released
  task automatic nmt(input logic [7:0] cmd);
    nmt_cmd = cmd;
    nmt_valid = 1'b1;
    @(negedge clk_sys);
    nmt_valid = 1'b0;
    nmt_cmd = ~cmd;
  endtask : nmt

  // guard request, caller sets the period
  task automatic guard;
    guard_req = 1'b1;
    @(negedge clk_sys);
    guard_req = 1'b0;
  endtask : guard

  // sync broadcast, caller spaces them
  task automatic sync;
    sync_rx = 1'b1;
    @(negedge clk_sys);
    sync_rx = 1'b0;
  endtask : sync
endmodule : cno_master_model
`default_nettype wire

// >>> tb/cno_node_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the node
module cno_node_checker (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       nmt_valid,
  input wire logic [7:0] nmt_cmd,
  input wire logic       guard_req,
  input wire logic       sync_rx,
  input wire logic       err_event,
  input wire logic [6:0] state_code_ff,
  input wire logic       guard_reply_ff,
  input wire logic [6:0] guard_code_ff,
  input wire logic       sync_taken_ff,
  input wire logic       emcy_tx_ff,
  input wire logic [3:0] rpdo_accept_ff,
  input wire logic [6:0] node_id_ff,
  input wire logic       led_red_ff,
  input wire logic       led_yellow_ff,
  input wire logic       led_green_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // state after management commands
  a_nmt_start: assert property (nmt_valid && nmt_cmd == 8'h01 && state_code_ff inside {7'h04, 7'h7f, 7'h05}
    |=> state_code_ff == 7'h05) else $error("start did not reach operational");
  a_nmt_stop: assert property (nmt_valid && nmt_cmd == 8'h02 && state_code_ff inside {7'h04, 7'h7f, 7'h05}
    |=> state_code_ff == 7'h04) else $error("stop did not reach prepared");
  a_nmt_reinit: assert property (nmt_valid && nmt_cmd inside {8'h80, 8'h81, 8'h82}
    && state_code_ff inside {7'h04, 7'h7f, 7'h05} |=> state_code_ff == 7'h7f)
    else $error("reset command did not reach pre-operational");
  a_nmt_ignore: assert property (nmt_valid && !(nmt_cmd inside {8'h01, 8'h02, 8'h80, 8'h81, 8'h82})
    && state_code_ff inside {7'h04, 7'h7f, 7'h05} |=> $stable(state_code_ff))
    else $error("unknown command changed state");
  // guard reply carries state at request
  a_guard_code: assert property (guard_req && state_code_ff != 7'h01
    |=> guard_reply_ff && guard_code_ff == $past(state_code_ff)) else $error("guard reply wrong");
  // services gated by state
  a_sync_gate: assert property (sync_taken_ff |-> $past(sync_rx)
    && $past(state_code_ff) inside {7'h7f, 7'h05}) else $error("sync taken in wrong state");
  a_emcy_gate: assert property (emcy_tx_ff |-> $past(err_event)
    && $past(state_code_ff) inside {7'h04, 7'h7f, 7'h05}) else $error("emergency in wrong state");
  a_rpdo_gate: assert property (rpdo_accept_ff != 4'h0
    |-> $past(state_code_ff) == 7'h05) else $error("receive pdo outside operational");
  a_led_onehot: assert property ($onehot({led_red_ff, led_yellow_ff, led_green_ff}))
    else $error("indicator not one colour");
  a_id_range: assert property (node_id_ff != 7'h00) else $error("node id zero");
endmodule : cno_node_checker
bind cno_node_top cno_node_checker u_chk (.*);
`default_nettype wire

// >>> tb/cno_node_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cno_node_top_tb_top import cno_pkg::*;;
  logic clk_sys = 1'b0, reset = 1'b1, startup_done = 1'b0, box_attached = 1'b1, cfg_id_wr = 1'b0;
  logic cfg_rate_wr = 1'b0, comm_error = 1'b0, guard_mon_en = 1'b0, err_event = 1'b0, cob_wr = 1'b0;
  logic nmt_valid, guard_req, sync_rx, guard_reply_ff, guard_fault_ff, sync_taken_ff, emcy_tx_ff;
  logic led_red_ff, led_yellow_ff, led_green_ff;
  logic [3:0] node_id_high_nibble_switch = 4'h1, node_id_low_nibble_switch = 4'h2;
  logic [3:0] bit_rate_select_switch = 4'h5, cfg_rate = 4'h0, cob_wr_sel = 4'h3;
  logic [3:0] tpdo_rtr = 4'h0, tpdo_event = 4'h0, rpdo_rx = 4'h0, tpdo_fire_ff, rpdo_accept_ff;
  logic [6:0] cfg_id = 7'h00, state_code_ff, guard_code_ff, node_id_ff;
  logic [7:0] nmt_cmd;
  logic [1:0] sdo_req = 2'h0, sdo_grant_ff;
  logic [2:0] rate_code_ff;
  logic [9:0] rate_kbps_ff;
  logic [10:0] cob_wr_data = 11'h123;
  logic [15:0] err_code = 16'h0000, sdo_subindex = 16'h0000, emcy_code_ff, sdo_subindex_ff;
  logic [31:0] sdo_index = 32'h0, tpdo_type = {8'hfc, 8'h00, 8'hfd, 8'hfe}, sdo_index_ff;
  logic [COB_NUM*COB_W-1:0] cob_table_ff;
  int n_mismatch = 0, n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  cno_node_top #(.GUARD_CYC(20)) DUT (.*);
  cno_master_model u_mst (.clk_sys(clk_sys), .nmt_valid(nmt_valid), .nmt_cmd(nmt_cmd),
                          .guard_req(guard_req), .sync_rx(sync_rx));

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic chk(input string nm, input logic [175:0] exp, input logic [175:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // whole identifier table against base plus node id
  task automatic chk_ids(input logic [6:0] id);
    for (int i = 0; i < COB_NUM; i++)
      chk("cob_id", COB_BASE[i] + (COB_ADD_ID[i] ? {4'h0, id} : 11'h000),
          cob_table_ff[i*COB_W+:COB_W]);
  endtask : chk_ids

  // or of transmit triggers over a few cycles
  task automatic pdo_window(output logic [3:0] seen);
    seen = 4'h0;
    repeat (4)
    begin
      seen |= tpdo_fire_ff;
      tick(1);
    end
  endtask : pdo_window

  task automatic cfg_write(input logic is_rate);
    {cfg_rate_wr, cfg_id_wr} = {is_rate, !is_rate};
    tick(1);
    {cfg_rate_wr, cfg_id_wr} = 2'b00;
    tick(2);
  endtask : cfg_write

  // bring-up through connecting and preparing
  task automatic t_startup;
    chk("state", 7'h01, state_code_ff);
    chk("rate", 10'h1f4, rate_kbps_ff);
    chk("node_id", 7'h3f, node_id_ff);
    chk("led", 3'b010, {led_red_ff, led_yellow_ff, led_green_ff});
    reset = 1'b0;
    tick(1);
    sdo_req = 2'b01;
    u_mst.guard();
    sdo_req = 2'b10;
    chk("sdo_grant", 2'b00, sdo_grant_ff);
    chk("guard_code", 7'h02, guard_code_ff);
    sdo_index = 32'h1006_0000;
    sdo_subindex = 16'h0500;
    err_event = 1'b1;
    u_mst.nmt(NMT_START);
    {sdo_req, err_event} = 3'b000;
    chk("sdo_grant", 2'b10, sdo_grant_ff);
    chk("sdo_index", 16'h1006, sdo_index_ff[31:16]);
    chk("sdo_sub", 8'h05, sdo_subindex_ff[15:8]);
    chk("emcy", 1'b0, emcy_tx_ff);
    chk("state", 7'h03, state_code_ff);
    startup_done = 1'b1;
    tick(1);
    chk("state", 7'h7f, state_code_ff);
    chk("node_id", 7'h12, node_id_ff);
    chk("rate_code", 3'h5, rate_code_ff);
    tick(2);
    chk("rate", 10'h032, rate_kbps_ff);
    chk("led", 3'b001, {led_red_ff, led_yellow_ff, led_green_ff});
    chk_ids(7'h12);
  endtask : t_startup

  // every command, guard code before each
  task automatic t_nmt;
    logic [7:0] cmd [8] = '{8'h02, 8'h01, 8'h82, 8'h01, 8'h81, 8'h01, 8'h80, 8'h03};
    logic [6:0] exp [8] = '{7'h04, 7'h05, 7'h7f, 7'h05, 7'h7f, 7'h05, 7'h7f, 7'h7f};
    logic [6:0] prev = 7'h7f;
    for (int i = 0; i < 8; i++)
    begin
      u_mst.guard();
      chk("guard_reply", 1'b1, guard_reply_ff);
      chk("guard_code", prev, guard_code_ff);
      u_mst.nmt(cmd[i]);
      chk("state", exp[i], state_code_ff);
      prev = exp[i];
    end
  endtask : t_nmt

  // process data gated by state, by transmission type
  task automatic t_pdo;
    logic [3:0] seen;
    u_mst.sync();
    chk("sync_taken", 1'b1, sync_taken_ff);
    {rpdo_rx, tpdo_event, err_event, err_code} = {4'hf, 4'h1, 1'b1, 16'h5a01};
    tick(1);
    {rpdo_rx, tpdo_event, err_event} = 9'h000;
    chk("rpdo", 4'h0, rpdo_accept_ff);
    chk("emcy_code", 16'h5a01, emcy_tx_ff ? emcy_code_ff : 16'h0);
    pdo_window(seen);
    chk("tpdo_fire", 4'h0, seen);
    u_mst.nmt(NMT_START);
    {rpdo_rx, tpdo_event, tpdo_rtr, sdo_req} = {4'b1001, 4'b0101, 4'b1010, 2'b01};
    {sdo_index, sdo_subindex} = {32'h0000_2010, 16'h001c};
    tick(1);
    {rpdo_rx, tpdo_event, tpdo_rtr, sdo_req} = 14'h0;
    chk("rpdo", 4'b1001, rpdo_accept_ff);
    chk("sdo_index", 16'h2010, sdo_grant_ff[0] ? sdo_index_ff[15:0] : 16'h0);
    chk("sdo_sub", 8'h1c, sdo_subindex_ff[7:0]);
    pdo_window(seen);
    chk("tpdo_fire", 4'b0011, seen);
    u_mst.sync();
    pdo_window(seen);
    chk("tpdo_fire", 4'b1100, seen);
  endtask : t_pdo

  // overrides, id change, rate table, indicator, guard watchdog
  task automatic t_ids;
    logic [9:0] kbps [8] = '{10'h3e8, 10'h320, 10'h1f4, 10'h0fa, 10'h07d, 10'h032, 10'h014, 10'h00a};
    cob_wr = 1'b1;
    tick(1);
    cob_wr = 1'b0;
    u_mst.nmt(NMT_RST_COMM);
    chk("cob_guard", 11'h123, cob_table_ff[3*COB_W+:COB_W]);
    cfg_id = 7'h00;
    cfg_write(1'b0);
    chk("node_id", 7'h12, node_id_ff);
    chk("led", 3'b100, {led_red_ff, led_yellow_ff, led_green_ff});
    cfg_id = 7'h7f;
    cfg_write(1'b0);
    chk_ids(7'h7f);
    cfg_rate = 4'h8;
    cfg_write(1'b1);
    chk("rate_code", 3'h5, rate_code_ff);
    for (int i = 0; i < 8; i++)
    begin
      cfg_rate = i[3:0];
      cfg_write(1'b1);
      chk("rate", kbps[i], rate_kbps_ff);
    end
    comm_error = 1'b1;
    tick(2);
    chk("led_red", 1'b1, led_red_ff);
    comm_error = 1'b0;
    guard_mon_en = 1'b1;
    u_mst.guard();
    tick(10);
    chk("guard_fault", 1'b0, guard_fault_ff);
    tick(15);
    chk("guard_fault", 1'b1, guard_fault_ff);
  endtask : t_ids

  task automatic complete_run;
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    tick(16);
    t_startup();
    t_nmt();
    t_pdo();
    t_ids();
    complete_run();
  end

  // hang guard, far beyond the roughly 120 cycles needed
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run();
  end
endmodule : cno_node_top_tb_top
`default_nettype wire
